// *** rtl/asp_pkg.sv ***
// Constants shared by the converter serial port and calibration sequencer
// Summary of operation
// - System offset mode: convert input, store zero-point, ready after 4 periods
// - Positive span mode: convert input, store positive span, ready after 4 periods
// - Negative span mode: convert input, store negative span, ready after 4 periods
// - Offset/internal gain: offset, then span updates every 3 periods, ready 3 later
// - System gain: negative span, reversed input to positive span, ready 1 later
// - Five 24-bit registers: result read-only, control and three calibrations
// - Byte addressed, multi-byte, selectable bit and byte order, any start
// - Two-wire uses the data line both ways; three-wire reads on output line
// - Clock-mode pin low: serial clock is a host input, transfers follow it
// - Clock-mode pin high: drive serial clock at oscillator/8, stall only high
// - Self clock: first edge 29 cycles after select, 8 rising edges, 27-cycle stall
// - Byte stall gives 32 cycles rise to rise; select sampling adds one
// - External clock: inactive select freezes the port, transfer later resumes
// - External clock read: outputs released as soon as select goes inactive
// - Self clock: started byte always completes; inactive select then stalls
// - Transfer paused at byte boundary resumes remaining bytes first
// - Self clocked read drives to last bit; stall release within one cycle
// - Three-bit mode field: conversion, self, offset, spans, offset/gain, gain
// - Ready low on result update, high after a complete result read
package asp_pkg;
  localparam int DW = 24;
  // Control register field layout
  localparam int CR_MSB_N_BIT = 1;
  localparam int CR_BD_BIT = 2;
  localparam int CR_3WIRE_BIT = 3;
  localparam int CR_MODE_LSB = 20;
  localparam logic [23:0] CR_RESET = 24'h00_0000;
  localparam logic [23:0] ZERO_RESET = 24'h00_0000;
  localparam logic [23:0] SPAN_RESET = 24'h80_0000;
  // Instruction byte fields
  localparam int IN_RW_BIT = 7;
  localparam int IN_MB_LSB = 5;
  localparam int IN_FSC_BIT = 4;
  localparam int IN_REG_LSB = 2;
  localparam logic [1:0] REG_RESULT = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_ZERO = 2'h2;
  localparam logic [1:0] REG_SPAN = 2'h3;
  // Operating mode codes
  localparam logic [2:0] MD_CONV = 3'h0;
  localparam logic [2:0] MD_SELF = 3'h1;
  localparam logic [2:0] MD_SYS_OFF = 3'h2;
  localparam logic [2:0] MD_SYS_POS = 3'h3;
  localparam logic [2:0] MD_SYS_NEG = 3'h4;
  localparam logic [2:0] MD_OFF_IGAIN = 3'h5;
  localparam logic [2:0] MD_SYS_GAIN = 3'h6;
  // Conversion period counts
  localparam logic [2:0] PER_SINGLE = 3'h4;
  localparam logic [2:0] PER_STEP = 3'h3;
  localparam logic [2:0] PER_GAIN_END = 3'h1;
  localparam logic [2:0] PER_SETTLE = 3'h3;
  // Self clock timing in oscillator cycles
  localparam logic [5:0] SC_START_LAST = 6'h1C;
  localparam logic [5:0] SC_BYTE_LAST = 6'h3C;
  localparam logic [5:0] SC_STALL_LAST = 6'h1A;
  localparam logic [2:0] SC_FALL_PH = 3'h0;
  localparam logic [2:0] SC_RISE_PH = 3'h4;
  typedef enum logic [1:0] {G_IDLE = 2'b00, G_START = 2'b01,
    G_BYTE = 2'b11, G_STALL = 2'b10} asp_gen_t;
  typedef enum logic [2:0] {SQ_RUN = 3'b000, SQ_OFF = 3'b001,
    SQ_POS = 3'b011, SQ_NEG = 3'b010, SQ_WAIT = 3'b110} asp_seq_t;
endpackage : asp_pkg

// *** rtl/asp_buf2.sv ***
// Two-entry valid/ready buffer for filter results
`timescale 1ns/1ps
module asp_buf2 #(
  parameter int W = 24
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic rp_q, rp_d, wp_q, wp_d;
  logic push, pop;

  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    mem_d = mem_q;
    rp_d = rp_q ^ pop;
    wp_d = wp_q ^ push;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    if (push)
    begin
      mem_d[wp_q] = in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      cnt_q <= 2'd0;
      rp_q <= 1'b0;
      wp_q <= 1'b0;
    end
    else
    begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      rp_q <= rp_d;
      wp_q <= wp_d;
    end
  end
endmodule : asp_buf2

// *** rtl/asp_top.sv ***
// Serial port, self clock generator and calibration sequencer
`timescale 1ns/1ps
module asp_top
  import asp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_mode_pin,
  input wire logic cs_n,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n,
  output logic serial_output_line,
  output logic serial_output_line_oe_n,
  output logic result_ready_n,
  input wire logic conv_done,
  input wire logic [DW-1:0] conv_data,
  output logic conv_ready,
  output logic [2:0] op_mode_select,
  output logic ain_short,
  output logic ref_switch_in,
  output logic ref_reverse,
  output logic input_reverse
);
  // Pin synchronisers: stage one feeds stage two only
  logic [1:0] mode_m, cs_m, sclk_m, sdi_m;
  logic mode_s, cs_s_n, sclk_s, sdi_s, sclk_p;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_m <= 2'b00;
      cs_m <= 2'b11;
      sclk_m <= 2'b11;
      sdi_m <= 2'b00;
      sclk_p <= 1'b1;
    end
    else
    begin
      mode_m <= {mode_m[0], clk_mode_pin};
      cs_m <= {cs_m[0], cs_n};
      sclk_m <= {sclk_m[0], sclk_i};
      sdi_m <= {sdi_m[0], sdio_i};
      sclk_p <= sclk_s;
    end
  end
  assign mode_s = mode_m[1];
  assign cs_s_n = cs_m[1];
  assign sclk_s = sclk_m[1];
  assign sdi_s = sdi_m[1];
  logic cs_act;
  assign cs_act = !cs_s_n;

  // Self clock generator
  asp_gen_t gst_q, gst_d;
  logic [5:0] gcnt_q, gcnt_d;
  logic sck_q, sck_d;
  logic rise_g, fall_g, rise_e, fall_e, rise, fall;
  always_comb
  begin
    gst_d = gst_q;
    gcnt_d = gcnt_q + 6'd1;
    sck_d = sck_q;
    if (fall_g)
    begin
      sck_d = 1'b0;
    end
    if (rise_g)
    begin
      sck_d = 1'b1;
    end
    unique case (gst_q)
      G_IDLE:
      begin
        gcnt_d = 6'd0;
        if (mode_s && cs_act)
        begin
          gst_d = G_START;
        end
      end
      G_START:
      begin
        if (gcnt_q == SC_START_LAST)
        begin
          gst_d = G_BYTE;
          gcnt_d = 6'd0;
        end
      end
      G_BYTE:
      begin
        if (gcnt_q == SC_BYTE_LAST)
        begin
          gst_d = G_STALL;
          gcnt_d = 6'd0;
        end
      end
      G_STALL:
      begin
        if (gcnt_q == SC_STALL_LAST)
        begin
          gst_d = cs_act ? G_BYTE : G_IDLE;
          gcnt_d = 6'd0;
        end
      end
    endcase
    if (!mode_s)
    begin
      gst_d = G_IDLE;
      sck_d = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      gst_q <= G_IDLE;
      gcnt_q <= 6'd0;
      sck_q <= 1'b1;
    end
    else
    begin
      gst_q <= gst_d;
      gcnt_q <= gcnt_d;
      sck_q <= sck_d;
    end
  end
  assign fall_g = (gst_q == G_BYTE) && (gcnt_q[2:0] == SC_FALL_PH);
  assign rise_g = (gst_q == G_BYTE) && (gcnt_q[2:0] == SC_RISE_PH);
  assign sclk_o = sck_q;
  assign sclk_oe_n = !mode_s;
  // host edges count only while selected
  assign rise_e = !mode_s && cs_act && sclk_s && !sclk_p;
  assign fall_e = !mode_s && cs_act && !sclk_s && sclk_p;
  assign rise = rise_e || rise_g;
  assign fall = fall_e || fall_g;

  // five 24-bit registers, serial engine state
  logic [DW-1:0] res_q, res_d, cr_q, cr_d, zero_q, zero_d;
  logic [DW-1:0] pos_q, pos_d, neg_q, neg_d;
  logic [7:0] instr_q, instr_d, rx_q, rx_d, tx_q, tx_d;
  logic [2:0] bit_q, bit_d;
  logic [1:0] left_q, left_d, byte_q, byte_d;
  logic ph_q, ph_d, rdy_q, rdy_d;
  asp_seq_t sq_q, sq_d;
  logic [2:0] per_q, per_d, md;
  logic msb_first, asc, rd_phase, rd_res, take, ready_set;
  logic [7:0] rx_new;
  logic [DW-1:0] buf_data;
  logic buf_valid;

  assign md = cr_q[CR_MODE_LSB +: 3];
  assign msb_first = !cr_q[CR_MSB_N_BIT];
  assign asc = cr_q[CR_BD_BIT];
  assign rd_phase = ph_q && !instr_q[IN_RW_BIT];
  assign rd_res = rd_phase && (instr_q[IN_REG_LSB +: 2] == REG_RESULT);
  assign rx_new = msb_first ? {rx_q[6:0], sdi_s} : {sdi_s, rx_q[7:1]};
  // Result stays steady while the host is reading it
  assign take = buf_valid && !rd_res;

  function automatic logic [7:0] pick(input logic [DW-1:0] w,
                                      input logic [1:0] i);
    pick = (i == 2'd3) ? 8'h00 : w[i*8 +: 8];
  endfunction : pick

  function automatic logic [7:0] rd_byte(input logic [7:0] ins,
    input logic [1:0] i, input logic [DW-1:0] r, input logic [DW-1:0] c,
    input logic [DW-1:0] z, input logic [DW-1:0] p, input logic [DW-1:0] n);
    unique case (ins[IN_REG_LSB +: 2])
      REG_RESULT: rd_byte = pick(r, i);
      REG_CTRL: rd_byte = pick(c, i);
      REG_ZERO: rd_byte = pick(z, i);
      REG_SPAN: rd_byte = pick(ins[IN_FSC_BIT] ? n : p, i);
    endcase
  endfunction : rd_byte

  always_comb
  begin
    logic [7:0] ins;
    logic [1:0] nb;
    logic [2:0] tgt;
    logic done;
    ins = ph_q ? instr_q : rx_new;
    nb = asc ? byte_q + 2'd1 : byte_q - 2'd1;
    tgt = PER_STEP;
    done = 1'b0;
    {res_d, cr_d, zero_d, pos_d, neg_d} = {res_q, cr_q, zero_q, pos_q, neg_q};
    {instr_d, rx_d, tx_d, bit_d} = {instr_q, rx_q, tx_q, bit_q};
    {left_d, byte_d, ph_d, per_d} = {left_q, byte_q, ph_q, per_q};
    sq_d = sq_q;
    ready_set = 1'b0;
    rdy_d = rdy_q;
    // phase and byte count kept across deselect
    if (fall && bit_q != 3'd0)
    begin
      tx_d = msb_first ? {tx_q[6:0], 1'b0} : {1'b0, tx_q[7:1]};
    end
    if (rise)
    begin
      rx_d = rx_new;
      bit_d = bit_q + 3'd1;
      if (bit_q == 3'd7 && !ph_q)
      begin
        instr_d = rx_new;
        ph_d = 1'b1;
        left_d = rx_new[IN_MB_LSB +: 2];
        byte_d = rx_new[1:0];
        tx_d = rd_byte(ins, rx_new[1:0], res_q, cr_q, zero_q, pos_q, neg_q);
      end
      else if (bit_q == 3'd7)
      begin
        if (instr_q[IN_RW_BIT])
        begin
          unique case (instr_q[IN_REG_LSB +: 2])
            REG_RESULT: ;
            REG_CTRL: cr_d[byte_q*8 +: 8] = rx_new;
            REG_ZERO: zero_d[byte_q*8 +: 8] = rx_new;
            REG_SPAN:
            begin
              if (instr_q[IN_FSC_BIT])
              begin
                neg_d[byte_q*8 +: 8] = rx_new;
              end
              else
              begin
                pos_d[byte_q*8 +: 8] = rx_new;
              end
            end
          endcase
          if (instr_q[IN_REG_LSB +: 2] == REG_CTRL && byte_q == 2'd2)
          begin
            per_d = 3'd0;
            unique case (rx_new[CR_MODE_LSB - 16 +: 3])
              MD_SELF, MD_SYS_OFF, MD_OFF_IGAIN: sq_d = SQ_OFF;
              MD_SYS_POS: sq_d = SQ_POS;
              MD_SYS_NEG, MD_SYS_GAIN: sq_d = SQ_NEG;
              default: sq_d = SQ_RUN;
            endcase
          end
        end
        if (left_q == 2'd0)
        begin
          ph_d = 1'b0;
          if (rd_res)
          begin
            rdy_d = 1'b0;
          end
        end
        else
        begin
          left_d = left_q - 2'd1;
          byte_d = nb;
          tx_d = rd_byte(instr_q, nb, res_q, cr_q, zero_q, pos_q, neg_q);
        end
      end
    end
    if (take)
    begin
      per_d = (per_q == 3'd7) ? per_q : per_q + 3'd1;
      unique case (sq_q)
        SQ_RUN: tgt = PER_SETTLE;
        SQ_OFF: tgt = (md == MD_SYS_OFF) ? PER_SINGLE : PER_STEP;
        SQ_POS: tgt = (md == MD_SYS_POS) ? PER_SINGLE : PER_STEP;
        SQ_NEG: tgt = (md == MD_SYS_NEG) ? PER_SINGLE : PER_STEP;
        SQ_WAIT: tgt = (md == MD_SYS_GAIN) ? PER_GAIN_END : PER_STEP;
      endcase
      if (per_q + 3'd1 >= tgt)
      begin
        per_d = 3'd0;
        unique case (sq_q)
          SQ_RUN:
          begin
            per_d = per_q;
            done = 1'b1;
          end
          SQ_OFF:
          begin
            zero_d = buf_data;
            done = (md == MD_SYS_OFF);
            sq_d = SQ_POS;
          end
          SQ_POS:
          begin
            pos_d = buf_data;
            done = (md == MD_SYS_POS);
            sq_d = (md == MD_SYS_GAIN) ? SQ_WAIT : SQ_NEG;
          end
          SQ_NEG:
          begin
            neg_d = buf_data;
            done = (md == MD_SYS_NEG);
            sq_d = (md == MD_SYS_GAIN) ? SQ_POS : SQ_WAIT;
          end
          SQ_WAIT: done = 1'b1;
        endcase
        if (done)
        begin
          res_d = buf_data;
          ready_set = 1'b1;
          cr_d[CR_MODE_LSB +: 3] = MD_CONV;
          sq_d = SQ_RUN;
          per_d = (sq_q == SQ_RUN) ? per_q : 3'd0;
        end
      end
    end
    if (ready_set)
    begin
      rdy_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      res_q <= '0;
      cr_q <= CR_RESET;
      zero_q <= ZERO_RESET;
      pos_q <= SPAN_RESET;
      neg_q <= SPAN_RESET;
      instr_q <= 8'h00;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      bit_q <= 3'd0;
      left_q <= 2'd0;
      byte_q <= 2'd0;
      ph_q <= 1'b0;
      rdy_q <= 1'b0;
      sq_q <= SQ_RUN;
      per_q <= 3'd0;
    end
    else
    begin
      {res_q, cr_q, zero_q, pos_q, neg_q} <= {res_d, cr_d, zero_d, pos_d, neg_d};
      {instr_q, rx_q, tx_q, bit_q} <= {instr_d, rx_d, tx_d, bit_d};
      {left_q, byte_q, ph_q, per_q} <= {left_d, byte_d, ph_d, per_d};
      sq_q <= sq_d;
      rdy_q <= rdy_d;
    end
  end

  asp_buf2 #(.W(DW)) u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(conv_done),
    .in_ready(conv_ready),
    .in_data(conv_data),
    .out_valid(buf_valid),
    .out_ready(!rd_res),
    .out_data(buf_data)
  );

  // drive only while reading and selected or mid-byte
  logic drive, tx_bit;
  assign drive = rd_phase && (cs_act || (mode_s && gst_q == G_BYTE));
  assign tx_bit = msb_first ? tx_q[7] : tx_q[0];
  assign sdio_o = tx_bit;
  assign sdio_oe_n = !(drive && !cr_q[CR_3WIRE_BIT]);
  assign serial_output_line = tx_bit;
  assign serial_output_line_oe_n = !(drive && cr_q[CR_3WIRE_BIT]);
  assign result_ready_n = !rdy_q;
  assign op_mode_select = md;
  assign ain_short = (md == MD_SELF) && (sq_q == SQ_OFF);
  assign ref_switch_in = (md == MD_SELF || md == MD_OFF_IGAIN) &&
                         (sq_q == SQ_POS || sq_q == SQ_NEG);
  assign ref_reverse = ref_switch_in && (sq_q == SQ_NEG);
  assign input_reverse = (md == MD_SYS_GAIN) && (sq_q == SQ_POS);

  property p_sclk_dir;
    @(posedge clk_sys) disable iff (rst) !mode_s |-> sclk_oe_n && sclk_o;
  endproperty
  a_sclk_dir: assert property (p_sclk_dir) else $error("sclk dir");
  property p_start;
    @(posedge clk_sys) disable iff (rst)
      (gst_q == G_START && gcnt_q == SC_START_LAST && mode_s) |=> fall_g;
  endproperty
  a_start: assert property (p_start) else $error("start delay");
  property p_stall;
    @(posedge clk_sys) disable iff (rst) gst_q == G_STALL |-> sclk_o;
  endproperty
  a_stall: assert property (p_stall) else $error("stall low");
  property p_byte;
    @(posedge clk_sys) disable iff (rst)
      (gst_q == G_BYTE && gcnt_q < SC_BYTE_LAST && mode_s) |=> gst_q == G_BYTE;
  endproperty
  a_byte: assert property (p_byte) else $error("byte cut");
  property p_release;
    @(posedge clk_sys) disable iff (rst)
      (!mode_s && !cs_act) |-> sdio_oe_n && serial_output_line_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("no release");
  property p_ready;
    @(posedge clk_sys) disable iff (rst) ready_set |=> !result_ready_n;
  endproperty
  a_ready: assert property (p_ready) else $error("ready late");
  property p_offset;
    @(posedge clk_sys) disable iff (rst)
      (take && sq_q == SQ_OFF && md == MD_SYS_OFF && per_q == 3'd3)
      |=> zero_q == $past(buf_data) && !result_ready_n;
  endproperty
  a_offset: assert property (p_offset) else $error("offset cal");
  property p_freeze;
    @(posedge clk_sys) disable iff (rst)
      (!mode_s && !cs_act && !rise_g) |=> $stable(bit_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("not frozen");
  property p_wire;
    @(posedge clk_sys) disable iff (rst)
      cr_q[CR_3WIRE_BIT] |-> sdio_oe_n;
  endproperty
  a_wire: assert property (p_wire) else $error("3-wire sdio");
endmodule : asp_top

// *** sim/asp_host_model.sv ***
// Host serial port model for external clock transfers
`timescale 1ns/1ps
module asp_host_model (
  input wire logic clk_sys,
  output logic cs_n,
  output logic sclk_i,
  output logic sdio_i,
  input wire logic sdio_o,
  input wire logic sdio_oe_n,
  input wire logic serial_output_line,
  input wire logic serial_output_line_oe_n,
  input wire logic sclk_o,
  input wire logic sclk_oe_n
);
  logic sclk_q = 1'b1;
  logic tx_q = 1'b0;
  logic drv_q = 1'b1;
  logic flip_q = 1'b0;
  initial cs_n = 1'b1;
  always @(posedge clk_sys) flip_q <= ~flip_q;
  // Released line toggles so a stale bit cannot pass for data
  assign sdio_i = !sdio_oe_n ? sdio_o : (drv_q ? tx_q : flip_q);
  assign sclk_i = !sclk_oe_n ? sclk_o : sclk_q;
  task automatic sel(input logic on);
    @(posedge clk_sys);
    cs_n <= !on;
    repeat (4) @(posedge clk_sys);
  endtask : sel
  task automatic pause(output logic off);
    sel(1'b0);
    off = sdio_oe_n & serial_output_line_oe_n;
    repeat (3)
    begin
      sclk_q <= 1'b0;
      repeat (4) @(posedge clk_sys);
      sclk_q <= 1'b1;
      repeat (4) @(posedge clk_sys);
    end
    sel(1'b1);
  endtask : pause
  task automatic byte_io(input logic [7:0] tx, input logic lsbf,
      input logic three, input logic drv, output logic [7:0] rx);
    int b;
    for (int i = 0; i < 8; i++)
    begin
      b = lsbf ? i : 7 - i;
      @(posedge clk_sys);
      sclk_q <= 1'b0;
      tx_q <= tx[b];
      drv_q <= drv;
      repeat (4) @(posedge clk_sys);
      rx[b] = three ? serial_output_line : sdio_i;
      sclk_q <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
  endtask : byte_io
endmodule : asp_host_model

// *** sim/asp_top_bench.sv ***
// Self-checking bench for the serial port and calibration sequencer
`timescale 1ns/1ps
module asp_top_bench;
  import asp_pkg::*;
  logic clk_sys, rst, clk_mode_pin, cs_n, sclk_i, sclk_o, sclk_oe_n;
  logic sdio_i, sdio_o, sdio_oe_n, sol, sol_oe_n, result_ready_n;
  logic conv_done, conv_ready, ain_short, ref_switch_in;
  logic ref_reverse, input_reverse, lsbf, asc, three, prev, oe15;
  logic [DW-1:0] conv_data;
  logic [DW-1:0] d [1:12];
  logic [DW-1:0] v;
  logic [2:0] op_mode_select;
  int failures, samples_checked, nr, ff;
  int rt [16];
  logic [3:0] steer;
  assign steer = {ain_short, ref_switch_in, ref_reverse, input_reverse};
  asp_top i_dut (.clk_sys(clk_sys), .rst(rst), .clk_mode_pin(clk_mode_pin),
    .cs_n(cs_n), .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n),
    .serial_output_line(sol), .serial_output_line_oe_n(sol_oe_n),
    .result_ready_n(result_ready_n), .conv_done(conv_done),
    .conv_data(conv_data), .conv_ready(conv_ready),
    .op_mode_select(op_mode_select), .ain_short(ain_short),
    .ref_switch_in(ref_switch_in), .ref_reverse(ref_reverse),
    .input_reverse(input_reverse));
  asp_host_model i_host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk_i(sclk_i),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n),
    .serial_output_line(sol), .serial_output_line_oe_n(sol_oe_n),
    .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic stop_test;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk_word(input string what, input logic [DW-1:0] exp,
      input logic [DW-1:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {23'h0, exp}, {23'h0, got});
  endtask : chk_bit
  task automatic chk_num(input string what, input int lo, input int hi,
      input int got);
    samples_checked++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_num
  // Instruction byte, then data bytes in the programmed order
  task automatic reg_io(input logic wr, input logic [2:0] adr,
      input logic [1:0] st, input int nb, input logic [31:0] x,
      input logic pz);
    logic [7:0] rx;
    logic [1:0] k;
    logic off;
    k = st;
    i_host.sel(1'b1);
    i_host.byte_io({wr, 2'(nb - 1), adr, st}, lsbf, three, 1'b1, rx);
    for (int i = 0; i < nb; i++)
    begin
      if (pz && i == 1)
      begin
        i_host.pause(off);
        chk_bit("data release", 1'b1, off);
      end
      i_host.byte_io(x[8*k+:8], lsbf, three, wr, rx);
      if (!wr)
        chk_word("read byte", {16'h0, x[8*k+:8]}, {16'h0, rx});
      k = asc ? k + 2'd1 : k - 2'd1;
    end
    i_host.sel(1'b0);
  endtask : reg_io
  task automatic do_reset(input logic m);
    @(posedge clk_sys);
    rst <= 1'b1;
    clk_mode_pin <= m;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    {lsbf, asc, three} = 3'b000;
    repeat (4) @(posedge clk_sys);
  endtask : do_reset
  task automatic conv(input logic [DW-1:0] x);
    int n;
    n = 0;
    @(posedge clk_sys);
    conv_done <= 1'b1;
    conv_data <= x;
    @(posedge clk_sys);
    while (conv_ready !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    conv_done <= 1'b0;
    if (n >= 20)
    begin
      failures++;
      stop_test();
    end
    repeat (6) @(posedge clk_sys);
  endtask : conv
  // Which conversion lands in each calibration register
  function automatic logic [DW-1:0] exp_cal(input logic [2:0] md, input int r);
    int k;
    case (md)
      MD_SELF, MD_OFF_IGAIN: k = 3 * (r + 1);
      MD_SYS_OFF: k = (r == 0) ? 4 : 0;
      MD_SYS_POS: k = (r == 1) ? 4 : 0;
      MD_SYS_NEG: k = (r == 2) ? 4 : 0;
      MD_SYS_GAIN: k = (r == 1) ? 6 : ((r == 2) ? 3 : 0);
      default: k = 0;
    endcase
    if (k != 0)
      return d[k];
    return (r == 0) ? ZERO_RESET : SPAN_RESET;
  endfunction : exp_cal
  // Analog steering after k conversions: short, ref in, ref reversed, input rev
  function automatic logic [3:0] exp_steer(input logic [2:0] md,
      input int k);
    logic [3:0] s;
    s = 4'h0;
    if ((md == MD_SELF || md == MD_OFF_IGAIN) && k < 3)
      s = {md == MD_SELF, 3'b000};
    else if ((md == MD_SELF || md == MD_OFF_IGAIN) && k < 9)
      s = {2'b01, k >= 6, 1'b0};
    else if (md == MD_SYS_GAIN && k >= 3 && k < 6)
      s = 4'h1;
    return s;
  endfunction : exp_steer
  task automatic run_cal(input logic [2:0] md, input int nrdy);
    do_reset(1'b0);
    reg_io(1'b1, {1'b0, REG_CTRL}, 2'd2, 1, {9'h0, md, 20'h0}, 1'b0);
    repeat (4) @(posedge clk_sys);
    chk_word("mode field", {21'h0, md}, {21'h0, op_mode_select});
    for (int k = 1; k <= nrdy; k++)
    begin
      conv(d[k]);
      chk_bit("ready", k != nrdy, result_ready_n);
      chk_word("steer", {20'h0, exp_steer(md, k)}, {20'h0, steer});
    end
    chk_word("mode end", 24'h00_0000, {21'h0, op_mode_select});
    reg_io(1'b0, 3'b010, 2'd2, 3, {8'h00, exp_cal(md, 0)}, 1'b0);
    reg_io(1'b0, 3'b011, 2'd2, 3, {8'h00, exp_cal(md, 1)}, 1'b0);
    reg_io(1'b0, 3'b111, 2'd2, 3, {8'h00, exp_cal(md, 2)}, 1'b0);
  endtask : run_cal
  initial
  begin
    {rst, clk_mode_pin, conv_done, conv_data} = {1'b1, 26'h0};
    failures = 0;
    samples_checked = 0;
    void'($urandom(32'h0000_6a49));
    for (int k = 1; k <= 12; k++)
      d[k] = 24'($urandom);
    do_reset(1'b0);
    reg_io(1'b0, 3'b001, 2'd2, 3, {8'h00, CR_RESET}, 1'b0);
    reg_io(1'b0, 3'b010, 2'd2, 3, {8'h00, ZERO_RESET}, 1'b0);
    reg_io(1'b0, 3'b011, 2'd2, 3, {8'h00, SPAN_RESET}, 1'b0);
    reg_io(1'b0, 3'b111, 2'd2, 3, {8'h00, SPAN_RESET}, 1'b0);
    for (int f = 0; f < 8; f++)
    begin
      v = 24'($urandom);
      reg_io(1'b1, 3'b001, 2'd0, 1, {28'h0, 3'(f), 1'b0}, 1'b0);
      {three, asc, lsbf} = 3'(f);
      reg_io(1'b1, 3'b010, 2'd3, 4, {8'hA5, v}, 1'b0);
      reg_io(1'b0, 3'b010, 2'($urandom), 4, {8'h00, v}, f[0]);
    end
    do_reset(1'b0);
    conv(d[1]);
    conv(d[2]);
    chk_bit("ready early", 1'b1, result_ready_n);
    conv(d[3]);
    chk_bit("ready set", 1'b0, result_ready_n);
    reg_io(1'b0, 3'b000, 2'd2, 3, {8'h00, d[3]}, 1'b1);
    chk_bit("ready clear", 1'b1, result_ready_n);
    reg_io(1'b1, 3'b000, 2'd2, 3, 32'h00FF_FFFF, 1'b0);
    reg_io(1'b0, 3'b000, 2'd2, 3, {8'h00, d[3]}, 1'b1);
    run_cal(MD_SELF, 12);
    run_cal(MD_SYS_OFF, 4);
    run_cal(MD_SYS_POS, 4);
    run_cal(MD_SYS_NEG, 4);
    run_cal(MD_OFF_IGAIN, 12);
    // reserved mode code is never written
    run_cal(MD_SYS_GAIN, 7);
    do_reset(1'b1);
    {nr, ff, prev, oe15} = {64'h0, 2'b11};
    i_host.tx_q <= 1'b0;
    i_host.drv_q <= 1'b1;
    i_host.cs_n <= 1'b0;
    for (int c = 1; c <= 700; c++)
    begin
      @(negedge clk_sys);
      if (prev && !sclk_o && ff == 0)
        ff = c;
      if (!prev && sclk_o)
      begin
        if (nr < 16)
          rt[nr] = c;
        nr++;
      end
      if (nr == 12)
        i_host.cs_n <= 1'b1;
      if (nr == 15)
        oe15 = sdio_oe_n;
      prev = sclk_o;
    end
    chk_num("first fall", 29, 35, ff);
    chk_num("bit period", 8, 8, rt[1] - rt[0]);
    chk_num("byte gap", 32, 32, rt[8] - rt[7]);
    chk_num("rise count", 16, 16, nr);
    chk_bit("clock parked", 1'b1, sclk_o);
    chk_bit("clock driven", 1'b0, sclk_oe_n);
    chk_bit("drive to end", 1'b0, oe15);
    chk_bit("stall release", 1'b1, sdio_oe_n);
    stop_test();
  end
endmodule : asp_top_bench
